/* src/usp_pkg.sv */
package usp_pkg;

    // Wishbone register offsets (byte addresses, one word each).
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_DIVISOR  = 8'h04;
    localparam logic [7:0] ADDR_ISRC     = 8'h08;
    localparam logic [7:0] ADDR_MSTAT    = 8'h0C;
    localparam logic [7:0] ADDR_THOLD    = 8'h10;
    localparam logic [7:0] ADDR_PSTAT    = 8'h14;
    localparam logic [7:0] ADDR_EVT      = 8'h18;
    localparam logic [7:0] ADDR_MASK     = 8'h1C;

    // Control register field positions.
    localparam int CTRL_SLEEP_EN_BIT = 4;
    localparam int CTRL_ENABLES_W    = 8;

    // Reset values.
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    localparam logic [3:0]  MASK_RESET    = 4'h0;

    // Interrupt source encodings (lower nibble).
    localparam logic [3:0] ISRC_NONE   = 4'h1;
    localparam logic [3:0] ISRC_MODEM  = 4'h0;

    // Event bit positions in the event status register.
    localparam int EVT_SLEEP_ENTER = 0;
    localparam int EVT_WAKE        = 1;
    localparam int EVT_PUMP_OFF    = 2;
    localparam int EVT_PUMP_ON     = 3;
    localparam int EVT_W           = 4;

    // Timing.
    localparam longint CLK_HZ          = 250_000_000;
    localparam longint IDLE_TIME_S     = 30;
    localparam longint IDLE_CYCLES     = IDLE_TIME_S * CLK_HZ;
    localparam longint PUMP_WAKE_NS    = 45_000;
    localparam longint PUMP_WAKE_CYC   = PUMP_WAKE_NS * CLK_HZ / 1_000_000_000;
    localparam longint OSC_START_NS    = 1_000;
    localparam longint OSC_START_CYC   = OSC_START_NS * CLK_HZ / 1_000_000_000;
    localparam int     CNT_W           = 34;

    typedef enum {
        USP_ACTIVE,
        USP_OSC_OFF,
        USP_OSC_START
    } usp_osc_state_t;

    typedef struct packed {
        logic       osc_running;
        logic       uart_asleep;
        logic       pump_on;
        logic       pump_ready;
        logic       full_sleep;
        logic       bus_isolated;
    } usp_power_t;

endpackage

/* src/usp_power_manager.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Sleep needs no pending interrupt, nonzero divisor, sleep enable, quiet modem, idle receive.
// - With autosleep pin low the charge pump always stays on.
// - Entering sleep stops the oscillator; its output pin shows no clock.
// - Receive start bit, transmit write or modem status bit wakes the UART.
// - Wake with sleep enabled raises interrupt coded 0x1; reading the source clears it.
// - Sleep is re-entered automatically once interrupts clear, never while one pends.
// - Auto sleep stays armed until the sleep enable bit is cleared.
// - Autosleep high and awake: pump stops after 30 s of idle lines.
// - Pump shutdown tri-states drivers; receivers and registers stay available.
// - Pump restarts on start bit, transmit load or modem rise; ready after 45 us.
// - UART asleep and autosleep pin high gives full sleep.
// - Full sleep ends on autosleep low or oscillator start; pump ready after 45 us.
// - Power-save pin high and UART asleep isolates host bus inputs.
// - In power-save only start bit or modem change wakes; bus activity is ignored.
// - Power-save returns after interrupts clear; persists until enable or pin drops.
// - Power-save wake interrupt only after oscillator runs; cleared by source read.
module usp_power_manager
    import usp_pkg::*;
#(
    parameter longint IDLE_COUNT = IDLE_CYCLES,
    parameter longint PUMP_COUNT = PUMP_WAKE_CYC,
    parameter longint OSC_COUNT  = OSC_START_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        charge_pump_autosleep_pin_i,
    input  wire logic        bus_isolation_pin_i,
    input  wire logic        rx_i,
    input  wire logic        cts_i,
    input  wire logic [3:0]  modem_in_i,
    input  wire logic        tx_active_i,
    input  wire logic        uart_int_pending_i,
    output logic             oscillator_output_pin_o,
    output logic             osc_enable_o,
    output logic             pump_enable_o,
    output logic             driver_oe_o,
    output logic             bus_isolated_o,
    output logic             irq_o
);

    logic [1:0] sync_acp;
    logic [1:0] sync_pws;
    logic [1:0] sync_rx;
    logic [1:0] sync_cts;
    logic [3:0] sync_modem [2];
    logic       charge_pump_autosleep_pin;
    logic       pws;
    logic       rx;
    logic       cts;
    logic [3:0] modem;
    logic       rx_prev;
    logic [3:0] modem_prev;

    logic [7:0]  ctrl;
    logic [15:0] divisor;
    logic [3:0]  msr_delta;
    logic        wake_int;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] evt_mask;
    logic [EVT_W-1:0] evt_set;

    usp_osc_state_t osc_state;
    logic [CNT_W-1:0] osc_cnt;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] pump_cnt;
    logic        pump_on;
    logic        pump_ready;
    logic        osc_div;
    logic        wake_seen;
    logic        ps_wake;

    usp_power_t  pwr;

    logic        req;
    logic        bus_open;
    logic        wr_hit;
    logic        rd_hit;
    logic        thr_write;
    logic        rx_start;
    logic [3:0]  modem_change;
    logic [3:0]  modem_rise;
    logic        sleep_en;
    logic        sleep_ok;
    logic        wake_evt;
    logic        pump_wake;
    logic        isolated;
    logic [3:0]  isrc_nib;
    logic [31:0] next_rdata;

    // Two-stage synchronisers; only the second stage, index [1], is read by logic.
    always_ff @(posedge clk_i) begin
        sync_acp <= {sync_acp[0], charge_pump_autosleep_pin_i};
        sync_pws <= {sync_pws[0], bus_isolation_pin_i};
        sync_rx  <= {sync_rx[0], rx_i};
        sync_cts <= {sync_cts[0], cts_i};
        sync_modem[0] <= modem_in_i;
        sync_modem[1] <= sync_modem[0];
    end

    assign charge_pump_autosleep_pin   = sync_acp[1];
    assign pws   = sync_pws[1];
    assign rx    = sync_rx[1];
    assign cts   = sync_cts[1];
    assign modem = sync_modem[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_prev    <= 1'b0;
            modem_prev <= 4'h0;
        end else begin
            rx_prev    <= rx;
            modem_prev <= modem;
        end
    end

    assign sleep_en     = ctrl[CTRL_SLEEP_EN_BIT];
    assign isolated     = pwr.bus_isolated;
    // While isolated the bus is cut off; requests are still acked so the master never hangs.
    assign req          = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_open     = !isolated;
    assign wr_hit       = req && wb_we_i && bus_open;
    assign rd_hit       = req && !wb_we_i && bus_open;
    assign thr_write    = wr_hit && (wb_adr_i == ADDR_THOLD) && wb_sel_i[0];
    assign rx_start     = rx && !rx_prev;
    assign modem_change = modem ^ modem_prev;
    assign modem_rise   = modem & ~modem_prev;
    assign wake_evt     = rx_start || thr_write || (|modem_change);
    assign pump_wake    = rx_start || thr_write || (|modem_rise);
    assign sleep_ok     = !uart_int_pending_i && !wake_int
                          && (divisor != 16'h0000) && sleep_en
                          && (msr_delta == 4'h0) && !rx;

    // Modem change indications, cleared by reading modem status; a change wins over the read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msr_delta <= 4'h0;
        end else if (rd_hit && wb_adr_i == ADDR_MSTAT) begin
            msr_delta <= modem_change;
        end else begin
            msr_delta <= msr_delta | modem_change;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= CTRL_RESET;
            divisor <= DIVISOR_RESET;
            evt_mask <= MASK_RESET;
        end else if (wr_hit) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    if (wb_sel_i[0]) ctrl <= wb_dat_i[7:0];
                end
                ADDR_DIVISOR: begin
                    if (wb_sel_i[0]) divisor[7:0]  <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) divisor[15:8] <= wb_dat_i[15:8];
                end
                ADDR_MASK: begin
                    if (wb_sel_i[0]) evt_mask <= wb_dat_i[EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Oscillator: stopped while asleep, started on wake and counted up before it counts as running.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_state <= USP_ACTIVE;
            osc_cnt   <= '0;
            wake_seen <= 1'b0;
        end else begin
            case (osc_state)
                USP_ACTIVE: begin
                    osc_cnt   <= '0;
                    wake_seen <= 1'b0;
                    if (sleep_ok && !wake_evt) begin
                        osc_state <= USP_OSC_OFF;
                    end
                end
                USP_OSC_OFF: begin
                    if (wake_evt || !sleep_en) begin
                        osc_state <= USP_OSC_START;
                        wake_seen <= wake_evt;
                    end
                end
                USP_OSC_START: begin
                    osc_cnt <= osc_cnt + 1'b1;
                    if (osc_cnt >= CNT_W'(OSC_COUNT - 1)) begin
                        osc_state <= USP_ACTIVE;
                    end
                end
                default: osc_state <= USP_ACTIVE;
            endcase
        end
    end

    assign ps_wake = (osc_state == USP_OSC_START) && (osc_cnt >= CNT_W'(OSC_COUNT - 1));

    // Wake interrupt raised once the oscillator runs; the source read clears it, set wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_int <= 1'b0;
        end else if (ps_wake && wake_seen && sleep_en) begin
            wake_int <= 1'b1;
        end else if (rd_hit && wb_adr_i == ADDR_ISRC) begin
            wake_int <= 1'b0;
        end
    end

    // Charge pump: idle timer, restart and settle delay.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pump_on    <= 1'b1;
            pump_ready <= 1'b1;
            pump_cnt   <= '0;
            idle_cnt   <= '0;
        end else begin
            if (tx_active_i || rx || cts || (|modem_change) || thr_write) begin
                idle_cnt <= '0;
            end else if (idle_cnt < CNT_W'(IDLE_COUNT)) begin
                idle_cnt <= idle_cnt + 1'b1;
            end
            if (!charge_pump_autosleep_pin) begin
                if (!pump_on) begin
                    pump_on  <= 1'b1;
                    pump_cnt <= '0;
                end
            end else if (pump_on && pump_wake) begin
                idle_cnt <= '0;
            end else if (pump_on && osc_state == USP_OSC_OFF) begin
                pump_on    <= 1'b0;
                pump_ready <= 1'b0;
            end else if (pump_on && idle_cnt >= CNT_W'(IDLE_COUNT)
                         && !tx_active_i && !rx && !cts) begin
                pump_on    <= 1'b0;
                pump_ready <= 1'b0;
            end else if (!pump_on && (pump_wake || osc_state == USP_OSC_START)) begin
                pump_on  <= 1'b1;
                pump_cnt <= '0;
                idle_cnt <= '0;
            end
            if (pump_on && !pump_ready) begin
                pump_cnt <= pump_cnt + 1'b1;
                if (pump_cnt >= CNT_W'(PUMP_COUNT - 1)) begin
                    pump_ready <= 1'b1;
                end
            end
        end
    end

    always_comb begin
        pwr.osc_running  = (osc_state == USP_ACTIVE);
        pwr.uart_asleep  = (osc_state == USP_OSC_OFF);
        pwr.pump_on      = pump_on;
        pwr.pump_ready   = pump_ready;
        pwr.full_sleep   = pwr.uart_asleep && !pump_on;
        pwr.bus_isolated = pwr.uart_asleep && pws && sleep_en;
    end

    // Event flags: read clears, a new event in the same cycle survives.
    assign evt_set = {1'b0,
                      1'b0,
                      ps_wake,
                      sleep_ok && !wake_evt && (osc_state == USP_ACTIVE)};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt <= '0;
        end else if (rd_hit && wb_adr_i == ADDR_EVT) begin
            evt <= evt_set;
        end else begin
            evt <= evt | evt_set;
        end
    end

    // The wake code shares 0x1 with no interrupt, so any other pending source hides it.
    assign isrc_nib = uart_int_pending_i ? ISRC_MODEM : ISRC_NONE;

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_CTRL:    next_rdata[7:0]  = ctrl;
            ADDR_DIVISOR: next_rdata[15:0] = divisor;
            ADDR_ISRC:    next_rdata[3:0]  = isrc_nib;
            ADDR_MSTAT:   next_rdata[7:0]  = {modem, msr_delta};
            ADDR_PSTAT:   next_rdata[5:0]  = pwr;
            ADDR_EVT:     next_rdata[EVT_W-1:0] = evt;
            ADDR_MASK:    next_rdata[EVT_W-1:0] = evt_mask;
            default:      next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= (req && !wb_we_i && bus_open) ? next_rdata : 32'h0000_0000;
        end
    end

    // Clock output toggles only while the oscillator runs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_div                 <= 1'b0;
            oscillator_output_pin_o <= 1'b0;
            osc_enable_o            <= 1'b1;
            pump_enable_o           <= 1'b1;
            driver_oe_o             <= 1'b1;
            bus_isolated_o          <= 1'b0;
            irq_o                   <= 1'b0;
        end else begin
            osc_div                 <= pwr.osc_running ? !osc_div : 1'b0;
            oscillator_output_pin_o <= osc_div;
            osc_enable_o            <= !pwr.uart_asleep;
            pump_enable_o           <= pump_on;
            driver_oe_o             <= pump_on && pump_ready;
            bus_isolated_o          <= pwr.bus_isolated;
            irq_o                   <= |(evt & evt_mask);
        end
    end

endmodule
`default_nettype wire

/* test/usp_power_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module usp_power_monitor #(
    parameter longint PUMP_COUNT = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        charge_pump_autosleep_pin_i,
    input wire logic        rx_i,
    input wire logic        uart_int_pending_i,
    input wire logic        oscillator_output_pin_o,
    input wire logic        osc_enable_o,
    input wire logic        pump_enable_o,
    input wire logic        driver_oe_o,
    input wire logic        bus_isolated_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    longint wait_cnt;
    // The settle count starts at pump turn-on whatever the oscillator does; slack covers the output registers.
    always_ff @(posedge clk_i) begin
        if (rst_i || !pump_enable_o || driver_oe_o) begin
            wait_cnt <= 0;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    property p_osc_quiet;
        !osc_enable_o && !$past(osc_enable_o) |-> !oscillator_output_pin_o;
    endproperty
    a_osc_quiet: assert property (p_osc_quiet) else $error("clock out while asleep");
    property p_pump_kept;
        !charge_pump_autosleep_pin_i [*5] |-> pump_enable_o;
    endproperty
    a_pump_kept: assert property (p_pump_kept) else $error("pump off with pin low");
    property p_drv_off;
        !pump_enable_o && !$past(pump_enable_o) |-> !driver_oe_o;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("drivers on without pump");
    property p_drv_settle;
        $rose(driver_oe_o) |-> $past(pump_enable_o, 3);
    endproperty
    a_drv_settle: assert property (p_drv_settle) else $error("drivers before settle");
    property p_pump_ready;
        wait_cnt <= PUMP_COUNT + 8;
    endproperty
    a_pump_ready: assert property (p_pump_ready) else $error("pump never ready");
    property p_iso_read;
        bus_isolated_o && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_dat_o == 32'h0;
    endproperty
    a_iso_read: assert property (p_iso_read) else $error("data leaked in isolation");
    property p_no_pend;
        $fell(osc_enable_o) |-> !$past(uart_int_pending_i) && !$past(uart_int_pending_i, 2);
    endproperty
    a_no_pend: assert property (p_no_pend) else $error("slept while pending");
    property p_wake_rx;
        !osc_enable_o && $rose(rx_i) |-> ##[1:20] osc_enable_o;
    endproperty
    a_wake_rx: assert property (p_wake_rx) else $error("no wake on start bit");
    c_sleep: cover property ($fell(osc_enable_o));
    c_full: cover property ($fell(pump_enable_o) && !osc_enable_o);
    c_iso: cover property ($rose(bus_isolated_o));
endmodule
bind usp_power_manager usp_power_monitor #(
    .PUMP_COUNT(PUMP_COUNT)
) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i),
    .charge_pump_autosleep_pin_i(charge_pump_autosleep_pin_i),
    .uart_int_pending_i(uart_int_pending_i), .osc_enable_o(osc_enable_o),
    .oscillator_output_pin_o(oscillator_output_pin_o), .pump_enable_o(pump_enable_o),
    .driver_oe_o(driver_oe_o), .bus_isolated_o(bus_isolated_o)
);
`default_nettype wire

/* test/usp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module usp_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output var  logic        done_o,
    output var  logic [31:0] rdat_o,
    output var  logic [7:0]  wb_adr_o,
    output var  logic [31:0] wb_dat_o,
    output logic      [3:0]  wb_sel_o,
    output var  logic        wb_we_o,
    output var  logic        wb_cyc_o,
    output logic             wb_stb_o,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_i
);
    initial begin
        {done_o, rdat_o, wb_adr_o, wb_dat_o, wb_we_o, wb_cyc_o} = '0;
    end
    assign wb_sel_o = 4'hF;
    assign wb_stb_o = wb_cyc_o;
    // The request stays frozen from launch until ack is sampled, then drops for a cycle.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            wb_cyc_o <= 1'b0;
        end else if (wb_cyc_o) begin
            if (wb_ack_i) begin
                wb_cyc_o <= 1'b0;
                rdat_o <= wb_dat_i;
                done_o <= 1'b1;
            end
        end else if (go_i) begin
            wb_cyc_o <= 1'b1;
            wb_we_o <= we_i;
            wb_adr_o <= adr_i;
            wb_dat_o <= dat_i;
        end
    end
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import usp_pkg::*;
    localparam longint IDLE_N = 50;
    localparam longint PUMP_N = 8;
    localparam longint OSC_N = 4;
    logic        clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, hwe = 1'b0;
    logic        charge_pump_autosleep_pin = 1'b0, iso = 1'b0, rx = 1'b0, cts = 1'b0, txa = 1'b0, pend = 1'b0;
    logic [3:0]  modem = 4'h0, w_sel;
    logic [7:0]  hadr = 8'h00, w_adr;
    logic [31:0] hdat = 32'h0, w_dat, w_q, rdat, rd;
    logic        w_we, w_cyc, w_stb, w_ack, done, oscp, osce, pmp, drv, isoo, irq;
    int          miscompares = 0, checks_done = 0, seed = 62, src;
    always #2 clk_i = ~clk_i;
    usp_host_model host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(hwe), .adr_i(hadr),
        .dat_i(hdat), .done_o(done), .rdat_o(rdat), .wb_adr_o(w_adr), .wb_dat_o(w_dat),
        .wb_sel_o(w_sel), .wb_we_o(w_we), .wb_cyc_o(w_cyc), .wb_stb_o(w_stb),
        .wb_dat_i(w_q), .wb_ack_i(w_ack));
    usp_power_manager #(.IDLE_COUNT(IDLE_N), .PUMP_COUNT(PUMP_N), .OSC_COUNT(OSC_N)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(w_adr), .wb_dat_i(w_dat), .wb_sel_i(w_sel),
        .wb_we_i(w_we), .wb_cyc_i(w_cyc), .wb_stb_i(w_stb), .wb_dat_o(w_q), .wb_ack_o(w_ack),
        .charge_pump_autosleep_pin_i(charge_pump_autosleep_pin), .bus_isolation_pin_i(iso), .rx_i(rx), .cts_i(cts),
        .modem_in_i(modem), .tx_active_i(txa), .uart_int_pending_i(pend),
        .oscillator_output_pin_o(oscp), .osc_enable_o(osce), .pump_enable_o(pmp),
        .driver_oe_o(drv), .bus_isolated_o(isoo), .irq_o(irq));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [3:0] exp_src(input logic other);
        return other ? ISRC_MODEM : ISRC_NONE;
    endfunction
    function automatic logic pick(input int s);
        case (s)
            0: return osce;
            1: return pmp;
            2: return drv;
            default: return isoo;
        endcase
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        go <= 1'b1;
        hwe <= w;
        hadr <= a;
        hdat <= d;
        @(posedge clk_i);
        go <= 1'b0;
        for (int n = 0; n < 50 && done !== 1'b1; n++) @(negedge clk_i);
        chk(done, 1'b1);
        if (done !== 1'b1) give_verdict();
        rd = rdat;
    endtask
    task automatic wait_for(input int s, input logic v);
        for (int n = 0; n < 300 && pick(s) !== v; n++) @(negedge clk_i);
        chk(pick(s), v);
        if (pick(s) !== v) give_verdict();
    endtask
    task automatic hold(input int s, input logic v, input int k);
        repeat (k) begin
            @(negedge clk_i);
            chk(pick(s), v);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({osce, pmp, drv, isoo, irq}, 5'b11100);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        bus(1'b0, ADDR_DIVISOR, 32'h0);
        chk(rd, DIVISOR_RESET);
        bus(1'b0, ADDR_MASK, 32'h0);
        chk(rd, MASK_RESET);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        bus(1'b1, ADDR_CTRL, 32'h10);
        hold(0, 1'b1, 20);
        rd = $random(seed);
        bus(1'b1, ADDR_DIVISOR, {16'h0, rd[15:0] | 16'h0001});
        wait_for(0, 1'b0);
        hold(1, 1'b1, 4);
        chk({oscp, irq}, 2'b00);
        bus(1'b1, ADDR_MASK, 32'h1);
        chk(irq, 1'b1);
        bus(1'b0, ADDR_EVT, 32'h0);
        chk({rd[EVT_SLEEP_ENTER], irq}, 2'b10);
        $display("test sleep entry done");
        for (int i = 0; i < 6; i++) begin
            src = (i < 3) ? i : $unsigned($random(seed)) % 3;
            if (src == 1) begin
                bus(1'b1, ADDR_THOLD, $random(seed));
            end else begin
                @(posedge clk_i);
                rx <= (src == 0);
                modem <= (src == 2) ? 4'h1 << i[1:0] : 4'h0;
            end
            wait_for(0, 1'b1);
            repeat (OSC_N + 6) @(negedge clk_i);
            chk(osce, 1'b1);
            @(posedge clk_i);
            rx <= 1'b0;
            modem <= 4'h0;
            pend <= (i == 4);
            bus(1'b0, ADDR_ISRC, 32'h0);
            chk(rd[3:0], exp_src(i == 4));
            if (src == 2 || i == 4) begin
                hold(0, 1'b1, 10);
            end
            @(posedge clk_i);
            pend <= 1'b0;
            bus(1'b0, ADDR_MSTAT, 32'h0);
            wait_for(0, 1'b0);
        end
        $display("test wake loop done");
        @(posedge clk_i);
        charge_pump_autosleep_pin <= 1'b1;
        wait_for(1, 1'b0);
        chk(drv, 1'b0);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h10);
        @(posedge clk_i);
        rx <= 1'b1;
        wait_for(1, 1'b1);
        chk(drv, 1'b0);
        wait_for(2, 1'b1);
        @(posedge clk_i);
        rx <= 1'b0;
        bus(1'b0, ADDR_ISRC, 32'h0);
        wait_for(1, 1'b0);
        @(posedge clk_i);
        charge_pump_autosleep_pin <= 1'b0;
        wait_for(1, 1'b1);
        chk(osce, 1'b0);
        $display("test full sleep done");
        @(posedge clk_i);
        iso <= 1'b1;
        wait_for(3, 1'b1);
        bus(1'b1, ADDR_THOLD, 32'h55);
        hold(0, 1'b0, 10);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        @(posedge clk_i);
        modem <= 4'h2;
        wait_for(0, 1'b1);
        wait_for(3, 1'b0);
        @(posedge clk_i);
        modem <= 4'h0;
        repeat (OSC_N + 6) @(negedge clk_i);
        bus(1'b0, ADDR_ISRC, 32'h0);
        chk(rd[3:0], exp_src(1'b0));
        bus(1'b0, ADDR_MSTAT, 32'h0);
        wait_for(3, 1'b1);
        @(posedge clk_i);
        iso <= 1'b0;
        wait_for(3, 1'b0);
        $display("test power save done");
        bus(1'b1, ADDR_CTRL, 32'h0);
        wait_for(0, 1'b1);
        bus(1'b0, ADDR_ISRC, 32'h0);
        hold(0, 1'b1, 20);
        $display("test sleep disable done");
        @(posedge clk_i);
        charge_pump_autosleep_pin <= 1'b1;
        txa <= 1'b1;
        cts <= 1'b1;
        hold(1, 1'b1, int'(IDLE_N + 20));
        @(posedge clk_i);
        txa <= 1'b0;
        cts <= 1'b0;
        wait_for(1, 1'b0);
        chk(drv, 1'b0);
        @(posedge clk_i);
        modem <= 4'h8;
        wait_for(1, 1'b1);
        wait_for(2, 1'b1);
        $display("test pump idle done");
        give_verdict();
    end
endmodule
`default_nettype wire
